// >>> rtl/rcw_pkg.sv
// Constants for the radio CRC, whitening and state register slice.
// Assumes a 12-bit byte address and 32-bit word-wide plain register port.
package rcw_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CRC_CONFIG  = 12'h0534;
  localparam logic [11:0] OFF_CRC_POLY    = 12'h0538;
  localparam logic [11:0] OFF_CRC_SEED    = 12'h053C;
  localparam logic [11:0] OFF_IFS         = 12'h0544;
  localparam logic [11:0] OFF_RSSI        = 12'h0548;
  localparam logic [11:0] OFF_STATE       = 12'h0550;
  localparam logic [11:0] OFF_WHITE_SEED  = 12'h0554;
  localparam logic [11:0] OFF_BCC         = 12'h0560;
  localparam logic [11:0] OFF_DAB_FIRST   = 12'h0600;
  localparam logic [11:0] OFF_DAB_LAST    = 12'h061C;
  // Field positions
  localparam int CRC_LEN_LSB  = 0;
  localparam int CRC_COV_LSB  = 8;
  localparam int WHITE_HW_BIT = 6;
  // Reset values
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
  localparam logic [31:0] RST_WHITE_SEED = 32'h0000_0040;
  // Coverage codes
  localparam logic [1:0] COV_INCLUDE = 2'h0;
  localparam logic [1:0] COV_SKIP    = 2'h1;
  localparam logic [1:0] COV_154     = 2'h2;
  // Transceiver state codes
  typedef enum logic [3:0] {
    ST_DISABLED          = 4'b0000,
    ST_RECEIVE_RAMPUP    = 4'b0001,
    ST_RECEIVE_IDLE      = 4'b0010,
    ST_RECEIVE           = 4'b0011,
    ST_RECEIVE_SHUTDOWN  = 4'b0100,
    ST_TRANSMIT_RAMPUP   = 4'b1001,
    ST_TRANSMIT_IDLE     = 4'b1010,
    ST_TRANSMIT          = 4'b1011,
    ST_TRANSMIT_SHUTDOWN = 4'b1100
  } rcw_state_t;
  // Timing
  localparam int US_NS       = 1000;
  localparam int CLK_NS      = 100;
  localparam int CYC_PER_US  = US_NS / CLK_NS;
endpackage

// >>> rtl/rcw_regs.sv
// Register slice: CRC setup, interframe spacing, state readout, whitening
// seed, bit counter compare and device address bases.
// Assumes transceiver inputs come from logic on clk; no synchronisers.
`timescale 1ns/1ps
// Overview of operation
// R01: Length code 0 disables CRC; codes 1..3 give 1..3 byte CRC.
// R02: Software programs three byte CRC in either long range coded mode.
// R03: Coverage 0 includes the address field in the CRC.
// R04: Coverage 1 starts the CRC after the address field.
// R05: Coverage 2 starts the CRC after the length field.
// R06: CRC seed comes from the seed register, reset zero.
// R07: Interframe spacing is counted in microseconds between packets.
// R08: State reads 0 disabled, 1..4 for receive ramp, idle, receive, shutdown.
// R09: State reads 9..12 for transmit ramp, idle, transmit, shutdown.
// R10: Whitening seed bit 6 is always one; reset value 0x40.
// R11: Whitening seed loads reversed: bit 0 feeds LFSR position 6.
// R12: Eight RW device address base registers from 0x600, reset zero.
// R13: Whitening applies only when whitening enable is one.
// R14: Address is base bytes plus one prefix byte.
// R15: Polynomial register is the generator for generation and checking.
// R16: State follows the transceiver machine; writes have no effect.
module rcw_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // From the transceiver
  input  wire logic [3:0]  radio_state,
  input  wire logic [6:0]  rssi_in,
  input  wire logic        long_range_mode,
  input  wire logic        whitening_enable,
  input  wire logic [2:0]  base_address_length,
  // To the packet datapath
  output logic             crc_enable,
  output logic      [1:0]  crc_byte_count,
  output logic      [31:0] crc_generator,
  output logic      [31:0] crc_start_value,
  output logic             crc_from_address,
  output logic             crc_after_address,
  output logic             crc_after_length,
  output logic             crc_len_illegal,
  output logic      [35:0] ifs_cycles,
  output logic             whiten_active,
  output logic      [6:0]  whiten_lfsr_seed,
  output logic      [2:0]  address_bytes,
  output logic      [31:0] bcc_value
);

  // Stored register fields and the read path
  logic [1:0]  len_q;
  logic [1:0]  cov_q;
  logic [31:0] poly_q;
  logic [31:0] seed_q;
  logic [31:0] ifs_q;
  logic [3:0]  state_q;
  logic [6:0]  rssi_q;
  logic [6:0]  white_q;
  logic [31:0] bcc_q;
  logic [31:0] dab [8];
  logic [31:0] next_rdata;
  logic        dab_hit;

  // Keeps only the low bytes that the chosen CRC length uses
  function automatic logic [31:0] crc_mask(input logic [1:0] n);
    case (n)
      2'h1:    crc_mask = 32'h0000_00FF;
      2'h2:    crc_mask = 32'h0000_FFFF;
      2'h3:    crc_mask = 32'h00FF_FFFF;
      default: crc_mask = 32'h0000_0000;
    endcase
  endfunction

  // Bit-reverses the seven whitening bits
  function automatic logic [6:0] rev7(input logic [6:0] v);
    for (int i = 0; i < 7; i++)
    begin
      rev7[i] = v[6 - i];
    end
  endfunction

  // Word-aligned hits inside the address base window
  assign dab_hit = (addr >= rcw_pkg::OFF_DAB_FIRST) && (addr <= rcw_pkg::OFF_DAB_LAST)
                   && (addr[1:0] == 2'h0);

  // CRC configuration register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      len_q <= rcw_pkg::RST_ZERO[1:0];
      cov_q <= rcw_pkg::RST_ZERO[1:0];
    end
    else if (wr && addr == rcw_pkg::OFF_CRC_CONFIG)
    begin
      len_q <= wdata[rcw_pkg::CRC_LEN_LSB +: 2];
      cov_q <= wdata[rcw_pkg::CRC_COV_LSB +: 2];
    end
  end

  // Polynomial, seed, spacing and bit counter compare
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      poly_q <= rcw_pkg::RST_ZERO;
      seed_q <= rcw_pkg::RST_ZERO;
      ifs_q  <= rcw_pkg::RST_ZERO;
      bcc_q  <= rcw_pkg::RST_ZERO;
    end
    else if (wr)
    begin
      if (addr == rcw_pkg::OFF_CRC_POLY)
        poly_q <= wdata;
      if (addr == rcw_pkg::OFF_CRC_SEED)
        seed_q <= wdata;
      if (addr == rcw_pkg::OFF_IFS)
        ifs_q <= wdata;
      if (addr == rcw_pkg::OFF_BCC)
        bcc_q <= wdata;
    end
  end

  // R10 hardwired seed bit
  // Bit 6 is forced on write, so a zero there can never be stored
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      white_q <= rcw_pkg::RST_WHITE_SEED[6:0];
    else if (wr && addr == rcw_pkg::OFF_WHITE_SEED)
      white_q <= wdata[6:0] | 7'(1 << rcw_pkg::WHITE_HW_BIT);
  end

  // R12 device address bases
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        dab[i] <= rcw_pkg::RST_ZERO;
    end
    else if (wr && dab_hit)
      dab[addr[4:2]] <= wdata;
  end

  // R16 state tracking
  // Sampled every cycle; no write path exists, so writes are dropped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= rcw_pkg::ST_DISABLED;
      rssi_q  <= rcw_pkg::RST_ZERO[6:0];
    end
    else
    begin
      state_q <= radio_state;
      rssi_q  <= rssi_in;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = rcw_pkg::RST_ZERO;
    if (dab_hit)
      next_rdata = dab[addr[4:2]];
    else
    begin
      case (addr)
        rcw_pkg::OFF_CRC_CONFIG: next_rdata = {22'h0, cov_q, 6'h0, len_q};
        rcw_pkg::OFF_CRC_POLY:   next_rdata = poly_q;
        rcw_pkg::OFF_CRC_SEED:   next_rdata = seed_q;
        rcw_pkg::OFF_IFS:        next_rdata = ifs_q;
        rcw_pkg::OFF_RSSI:       next_rdata = {25'h0, rssi_q};
        // R08 R09 state readout
        rcw_pkg::OFF_STATE:      next_rdata = {28'h0, state_q};
        rcw_pkg::OFF_WHITE_SEED: next_rdata = {25'h0, white_q};
        rcw_pkg::OFF_BCC:        next_rdata = bcc_q;
        default:                 next_rdata = rcw_pkg::RST_ZERO;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= rcw_pkg::RST_ZERO;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= rcw_pkg::RST_ZERO;
  end

  // R01 length decode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crc_enable     <= 1'b0;
      crc_byte_count <= 2'h0;
    end
    else
    begin
      crc_enable     <= (len_q != 2'h0);
      crc_byte_count <= len_q;
    end
  end

  // R15 R06 polynomial and seed, trimmed to the CRC length
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crc_generator   <= rcw_pkg::RST_ZERO;
      crc_start_value <= rcw_pkg::RST_ZERO;
    end
    else
    begin
      crc_generator   <= poly_q & crc_mask(len_q);
      crc_start_value <= seed_q & crc_mask(len_q);
    end
  end

  // R03 R04 R05 coverage decode
  // Reserved code 3 selects no start point, so the datapath stalls safe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crc_from_address  <= 1'b1;
      crc_after_address <= 1'b0;
      crc_after_length  <= 1'b0;
    end
    else
    begin
      crc_from_address  <= (cov_q == rcw_pkg::COV_INCLUDE);
      crc_after_address <= (cov_q == rcw_pkg::COV_SKIP);
      crc_after_length  <= (cov_q == rcw_pkg::COV_154);
    end
  end

  // R02 flags a long range mode with a length other than three bytes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_len_illegal <= 1'b0;
    else
      crc_len_illegal <= long_range_mode && (len_q != 2'h3);
  end

  // R07 microseconds to clock cycles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ifs_cycles <= 36'h0_0000_0000;
    else
      ifs_cycles <= {4'h0, ifs_q} * 36'(rcw_pkg::CYC_PER_US);
  end

  // R13 R11 whitening seed, reversed into LFSR order
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      whiten_active    <= 1'b0;
      whiten_lfsr_seed <= 7'h00;
    end
    else
    begin
      whiten_active    <= whitening_enable;
      whiten_lfsr_seed <= whitening_enable ? rev7(white_q) : 7'h00;
    end
  end

  // R14 address is base bytes plus one prefix byte
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      address_bytes <= 3'h1;
      bcc_value     <= rcw_pkg::RST_ZERO;
    end
    else
    begin
      address_bytes <= base_address_length + 3'h1;
      bcc_value     <= bcc_q;
    end
  end

  // Checks on clk; the edge that releases reset still runs the reset branch,
  // so checks that compare against inputs wait for arst_n sampled high
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Zero written into the hardwired whitening bit
  sequence s_wr_white0;
    wr && addr == rcw_pkg::OFF_WHITE_SEED && !wdata[6];
  endsequence

  // Seed write, then two cycles with a three byte CRC length
  sequence s_seed_len3;
    (wr && addr == rcw_pkg::OFF_CRC_SEED) ##1 (len_q == 2'h3) [*2];
  endsequence

  // Address base write, then a read of that word in the next cycle
  sequence s_dab_wr_rd;
    (wr && dab_hit) ##1 (rd && addr == $past(addr));
  endsequence

  // R01 length decode
  a_crc_len_off: assert property (len_q == 2'h0 |=> !crc_enable) // R01
    else $error("CRC enabled with zero length");
  a_crc_len_on: assert property (len_q != 2'h0 |=> // R01
    crc_enable && crc_byte_count == $past(len_q))
    else $error("CRC length not applied");

  // R02 long range length flag
  a_len_flag: assert property (arst_n && long_range_mode && len_q != 2'h3 |=> // R02
    crc_len_illegal)
    else $error("Illegal long range length not flagged");

  // R03 R04 R05 coverage decode
  a_cov_include: assert property (cov_q == 2'h0 |=> // R03
    crc_from_address && !crc_after_address)
    else $error("Address not covered");
  a_cov_skip: assert property (cov_q == 2'h1 |=> // R04
    crc_after_address && !crc_from_address)
    else $error("Address not skipped");
  a_cov_after_len: assert property (cov_q == 2'h2 |=> crc_after_length) // R05
    else $error("802.15.4 coverage missing");

  // R06 seed reaches the datapath
  a_seed_apply: assert property (s_seed_len3 |-> // R06
    crc_start_value[23:0] == $past(wdata[23:0], 2))
    else $error("CRC seed not applied");

  // R10 R11 R13 whitening seed
  a_white_bit6: assert property (s_wr_white0 |=> // R10
    white_q[6] ##1 (!whiten_active || whiten_lfsr_seed[0]))
    else $error("Whitening bit 6 lost");
  a_white_rev: assert property (whitening_enable |=> // R11
    whiten_lfsr_seed[6] == $past(white_q[0]))
    else $error("Whitening seed not reversed");
  a_white_off: assert property (!whitening_enable |=> // R13
    whiten_lfsr_seed == 7'h00 && !whiten_active)
    else $error("Whitening active while disabled");

  // R08 R16 state readout and tracking
  a_state_read: assert property (rd && addr == rcw_pkg::OFF_STATE |=> // R08
    rdata[3:0] == $past(state_q))
    else $error("State readout wrong");
  a_state_follow: assert property (arst_n |=> state_q == $past(radio_state)) // R16
    else $error("State not tracking");

  // R07 spacing conversion
  a_ifs_scale: assert property (arst_n |=> // R07
    ifs_cycles == {4'h0, $past(ifs_q)} * 36'(rcw_pkg::CYC_PER_US))
    else $error("Spacing count wrong");

  // R12 address base readback
  a_dab_write: assert property (s_dab_wr_rd |=> rdata == $past(wdata, 2)) // R12
    else $error("Address base readback wrong");

  // R15 R14 polynomial and address length
  a_poly_apply: assert property (len_q == 2'h2 |=> // R15
    crc_generator == {16'h0, $past(poly_q[15:0])})
    else $error("Polynomial not applied");
  a_addr_len: assert property (arst_n |=> // R14
    address_bytes == $past(base_address_length) + 3'h1)
    else $error("Address length wrong");
endmodule

// >>> dv/radio_crc_whitening_state_regs_bench.sv
// Self-checking bench for the CRC, whitening and state register slice.
// Assumes rcw_pkg and rcw_regs are compiled first; bench drives every port.
`timescale 1ns/1ps
module radio_crc_whitening_state_regs_bench;
  // Clock, reset and register port
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  // Transceiver side
  logic [3:0]  radio_state = 4'h0;
  logic [6:0]  rssi_in = 7'h55;
  logic        long_range_mode = 1'b0;
  logic        whitening_enable = 1'b0;
  logic [2:0]  base_address_length = 3'h3;
  // Datapath side
  logic        crc_enable, crc_from_address, crc_after_address, crc_after_length;
  logic        crc_len_illegal, whiten_active;
  logic [1:0]  crc_byte_count;
  logic [31:0] crc_generator, crc_start_value, bcc_value;
  logic [35:0] ifs_cycles;
  logic [6:0]  whiten_lfsr_seed;
  logic [2:0]  address_bytes;
  int          fails = 0;
  int          compares = 0;
  logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC};

  // Half period of 50 ns gives 10 MHz
  always #50 clk = ~clk;

  rcw_regs i_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .radio_state(radio_state), .rssi_in(rssi_in),
    .long_range_mode(long_range_mode), .whitening_enable(whitening_enable),
    .base_address_length(base_address_length), .crc_enable(crc_enable),
    .crc_byte_count(crc_byte_count), .crc_generator(crc_generator),
    .crc_start_value(crc_start_value), .crc_from_address(crc_from_address),
    .crc_after_address(crc_after_address), .crc_after_length(crc_after_length),
    .crc_len_illegal(crc_len_illegal), .ifs_cycles(ifs_cycles),
    .whiten_active(whiten_active), .whiten_lfsr_seed(whiten_lfsr_seed),
    .address_bytes(address_bytes), .bcc_value(bcc_value)
  );

  // Prints the counts and the verdict, then stops
  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Four-state compare, so an unknown never passes
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, launched just after an edge
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Write, then a read of the same word in the very next cycle
  task automatic wr_rd_chk(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, d);
  endtask

  // Outputs lag the registers by one cycle
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    rd_chk(rcw_pkg::OFF_CRC_CONFIG, 32'h0000_0000);
    rd_chk(rcw_pkg::OFF_CRC_SEED, 32'h0000_0000);
    rd_chk(rcw_pkg::OFF_WHITE_SEED, 32'h0000_0040);
    for (int n = 0; n < 8; n++)
      rd_chk(rcw_pkg::OFF_DAB_FIRST + 12'(4 * n), 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(rcw_pkg::OFF_CRC_CONFIG, 32'(i));
      settle();
      chk(crc_enable, i != 0);
      chk(crc_byte_count, 36'(i));
    end
    for (int c = 0; c < 3; c++)
    begin
      wr_reg(rcw_pkg::OFF_CRC_CONFIG, 32'((c << 8) | 3));
      settle();
      chk({crc_from_address, crc_after_address, crc_after_length}, 36'(4 >> c));
    end
    rd_chk(rcw_pkg::OFF_CRC_CONFIG, 32'h0000_0203);
    long_range_mode <= 1'b1;
    wr_reg(rcw_pkg::OFF_CRC_CONFIG, 32'h0000_0002);
    settle();
    chk(crc_len_illegal, 1'b1);
    // polynomial and seed trimmed to two bytes
    wr_reg(rcw_pkg::OFF_CRC_POLY, 32'h1234_5678);
    wr_reg(rcw_pkg::OFF_CRC_SEED, 32'hAABB_CCDD);
    long_range_mode <= 1'b0;
    settle();
    chk(crc_len_illegal, 1'b0);
    chk(crc_generator, 36'h0_0000_5678);
    chk(crc_start_value, 36'h0_0000_CCDD);
    rd_chk(rcw_pkg::OFF_CRC_POLY, 32'h1234_5678);
    rd_chk(rcw_pkg::OFF_CRC_SEED, 32'hAABB_CCDD);
    // Three byte length keeps three bytes of seed and polynomial
    wr_reg(rcw_pkg::OFF_CRC_CONFIG, 32'h0000_0003);
    wr_reg(rcw_pkg::OFF_CRC_SEED, 32'h1122_3344);
    settle();
    chk(crc_start_value, 36'h0_0022_3344);
    chk(crc_generator, 36'h0_0034_5678);
    // spacing in microseconds, largest value too
    wr_reg(rcw_pkg::OFF_IFS, 32'h0000_0096);
    settle();
    chk(ifs_cycles, 36'(150 * rcw_pkg::CYC_PER_US));
    wr_reg(rcw_pkg::OFF_IFS, 32'hFFFF_FFFF);
    settle();
    chk(ifs_cycles, 36'h0_FFFF_FFFF * 36'(rcw_pkg::CYC_PER_US));
    foreach (codes[k])
    begin
      radio_state <= codes[k];
      rd_chk(rcw_pkg::OFF_STATE, 32'(codes[k]));
    end
    wr_reg(rcw_pkg::OFF_STATE, 32'h0000_0005);
    rd_chk(rcw_pkg::OFF_STATE, 32'h0000_000C);
    rd_chk(rcw_pkg::OFF_RSSI, 32'h0000_0055);
    whitening_enable <= 1'b1;
    wr_reg(rcw_pkg::OFF_WHITE_SEED, 32'h0000_0003);
    rd_chk(rcw_pkg::OFF_WHITE_SEED, 32'h0000_0043);
    chk(whiten_lfsr_seed, 36'h0_0000_0061);
    chk(whiten_active, 1'b1);
    wr_reg(rcw_pkg::OFF_WHITE_SEED, 32'hFFFF_FF80);
    rd_chk(rcw_pkg::OFF_WHITE_SEED, 32'h0000_0040);
    whitening_enable <= 1'b0;
    settle();
    chk(whiten_active, 1'b0);
    chk(whiten_lfsr_seed, 36'h0_0000_0000);
    for (int n = 0; n < 8; n++)
      wr_reg(rcw_pkg::OFF_DAB_FIRST + 12'(4 * n), 32'hA5A5_0000 | 32'(n));
    for (int n = 0; n < 8; n++)
      rd_chk(rcw_pkg::OFF_DAB_FIRST + 12'(4 * n), 32'hA5A5_0000 | 32'(n));
    wr_rd_chk(rcw_pkg::OFF_DAB_FIRST + 12'h01C, 32'h5A5A_0007);
    wr_reg(12'h540, 32'hFFFF_FFFF);
    rd_chk(12'h540, 32'h0000_0000);
    rd_chk(12'h620, 32'h0000_0000);
    // address is base plus prefix byte
    base_address_length <= 3'h2;
    wr_reg(rcw_pkg::OFF_BCC, 32'hDEAD_BEEF);
    settle();
    chk(address_bytes, 36'h0_0000_0003);
    chk(bcc_value, 36'h0_DEAD_BEEF);
    rd_chk(rcw_pkg::OFF_BCC, 32'hDEAD_BEEF);
    // Second reset in mid-run restores the defaults
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(rcw_pkg::OFF_WHITE_SEED, 32'h0000_0040);
    rd_chk(rcw_pkg::OFF_DAB_FIRST, 32'h0000_0000);
    give_verdict();
  end
endmodule
